// ---- gate_fault_supervisor.sv ----
// Notes on behaviour
// - Switching to the opposite transistor starts blanking when the guard interval ends.
// - Switching on from high impedance starts blanking at once after the command.
// - Blank codes 000-111 give 625ns,1,1.25,1.5,2,3,4,16us; reset code 100.
// - Every new turn-on is blanked, including re-enable after supply faults.
// - Two-bit map per half-bridge picks timing pair 1 to 4.
// - Active and freewheel transistors have separate timing registers.
// - Pull-downs follow own diag bit and pull-ups are on, both only while driver active.
// - Output level bits report each half-bridge output while off.
// - Output level bit reads 0 while mode is 01 or 10.
// - Thermal warning latches; cleared by status clear once condition is gone.
// - Thermal shutdown turns drivers and pump off, sets supply, shutdown, pump flags.
// - After thermal shutdown pump stays off until condition gone and status cleared; drivers until a clear 64us after that.
// - Supply low turns transistors off and latches supply, low and pump flags.
// - Supply low flag clears only on status clear with supply above turn-on.
// - Supply high turns off transistors and pump; selectable level; latches flags.
// - Pump restarts below recovery level while transistors stay off.
// - Supply high flag clears only on status clear below recovery level.
// - Logic supply reset clears all logic and switches gate drivers off.
// - Pump low discharges statically for guard interval, then off; latches flags.
// - Pump flag clears on status clear with pump ok, 64us after supply or thermal recovery.
// - Drain fault is reported only after blanking with filtered violation present.
`include "gfs_consts.svh"

module gate_fault_supervisor (
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire gfs_pkg::reg_addr_type addr,
	input  wire gfs_pkg::reg_data_type wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output gfs_pkg::reg_data_type      rdata,
	input  wire logic                  temp_warn_in,
	input  wire logic                  temp_shutdown_in,
	input  wire logic                  supply_below_off_in,
	input  wire logic                  supply_above_on_in,
	input  wire logic                  supply_over1_in,
	input  wire logic                  supply_over2_in,
	input  wire logic                  supply_below_rec_in,
	input  wire logic                  pump_ok_in,
	input  wire gfs_pkg::bridge_vec_type drain_over_in,
	input  wire gfs_pkg::bridge_vec_type out_level_in,
	output gfs_pkg::bridge_vec_type    high_on,
	output gfs_pkg::bridge_vec_type    low_on,
	output gfs_pkg::bridge_vec_type    static_discharge,
	output logic [1:0]                 static_discharge_current,
	output gfs_pkg::bridge_vec_type    blank_active,
	output gfs_pkg::bridge_vec_type    diag_pulldown_on,
	output logic                       diag_pullup_on,
	output logic                       pump_enable,
	output logic                       global_error
);
	import gfs_pkg::*;

	// ************************************************************
	// Timing functions
	// ************************************************************
	function automatic logic [9:0] blank_cycles(input logic [2:0] c);
		case (c)
			3'h0: blank_cycles = 10'(`NS_TO_CYC(`BLANK_T0_NS));
			3'h1: blank_cycles = 10'(`NS_TO_CYC(`BLANK_T1_NS));
			3'h2: blank_cycles = 10'(`NS_TO_CYC(`BLANK_T2_NS));
			3'h3: blank_cycles = 10'(`NS_TO_CYC(`BLANK_T3_NS));
			3'h4: blank_cycles = 10'(`NS_TO_CYC(`BLANK_T4_NS));
			3'h5: blank_cycles = 10'(`NS_TO_CYC(`BLANK_T5_NS));
			3'h6: blank_cycles = 10'(`NS_TO_CYC(`BLANK_T6_NS));
			default: blank_cycles = 10'(`NS_TO_CYC(`BLANK_T7_NS));
		endcase
	endfunction

	function automatic logic [9:0] guard_cycles(input logic [2:0] c);
		case (c)
			3'h0: guard_cycles = 10'(`NS_TO_CYC(`GUARD_T0_NS));
			3'h1: guard_cycles = 10'(`NS_TO_CYC(`GUARD_T1_NS));
			3'h2: guard_cycles = 10'(`NS_TO_CYC(`GUARD_T2_NS));
			3'h3: guard_cycles = 10'(`NS_TO_CYC(`GUARD_T3_NS));
			3'h4: guard_cycles = 10'(`NS_TO_CYC(`GUARD_T4_NS));
			3'h5: guard_cycles = 10'(`NS_TO_CYC(`GUARD_T5_NS));
			3'h6: guard_cycles = 10'(`NS_TO_CYC(`GUARD_T6_NS));
			default: guard_cycles = 10'(`NS_TO_CYC(`GUARD_T7_NS));
		endcase
	endfunction

	// Pair n of register a (pairs 1,2) or b (pairs 3,4); field 0 guard, 1 blank
	function automatic logic [2:0] pair_field(input logic [11:0] a, input logic [11:0] b,
			input logic [1:0] pair, input logic blank);
		logic [11:0] r;
		r = pair[1] ? b : a;
		r = r >> (pair[0] ? 6 : 0);
		r = r >> (blank ? 3 : 0);
		pair_field = r[2:0];
	endfunction

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [15:0] raw_in;
	logic [15:0] s1_r;
	logic [15:0] s2_r;
	logic [15:0] s3_r;
	logic [15:0] flt_r;

	assign raw_in = {out_level_in, drain_over_in, pump_ok_in, supply_below_rec_in, supply_over2_in,
		supply_over1_in, supply_above_on_in, supply_below_off_in, temp_shutdown_in, temp_warn_in};

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1_r  <= 16'h0000;
			s2_r  <= 16'h0000;
			s3_r  <= 16'h0000;
			flt_r <= 16'h0000;
		end else begin
			s1_r  <= raw_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			flt_r <= (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
		end
	end

	logic       warn_s;
	logic       shutdown_s;
	logic       sup_low_s;
	logic       sup_on_s;
	logic       sup_high_s;
	logic       sup_rec_s;
	logic       pump_ok_s;
	logic [3:0] drain_s;
	logic [3:0] level_s;

	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0]  pair_map_r;
	logic [11:0] act_a_r;
	logic [11:0] act_b_r;
	logic [11:0] fw_a_r;
	logic [11:0] fw_b_r;
	logic [15:0] bctrl_r;
	logic [3:0]  diag_r;
	logic        stat_clr;
	logic        drain_clr;

	assign stat_clr  = wr && (addr == `OFS_GEN_STATUS);
	assign drain_clr = wr && (addr == `OFS_DRAIN_STATUS);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pair_map_r <= `RST_PAIR_MAP;
			act_a_r    <= `RST_TIMING;
			act_b_r    <= `RST_TIMING;
			fw_a_r     <= `RST_TIMING;
			fw_b_r     <= `RST_TIMING;
			bctrl_r    <= `RST_BRIDGE_CTRL;
			diag_r     <= `RST_DIAG_CURRENT;
		end else if (wr) begin
			case (addr)
				`OFS_PAIR_MAP:     pair_map_r <= wdata[7:0];
				`OFS_ACT_A:        act_a_r    <= wdata[11:0];
				`OFS_ACT_B:        act_b_r    <= wdata[11:0];
				`OFS_FW_A:         fw_a_r     <= wdata[11:0];
				`OFS_FW_B:         fw_b_r     <= wdata[11:0];
				`OFS_BRIDGE_CTRL:  bctrl_r    <= wdata[15:0];
				`OFS_DIAG_CURRENT: diag_r     <= wdata[3:0];
				default: ;
			endcase
		end
	end

	logic       passive;
	logic       ov_sel;
	logic [7:0] mode_v;
	logic [3:0] fw_role;

	// ************************************************************
	// Fault flags
	// ************************************************************
	logic tw_r;
	logic tsd_r;
	logic uv_r;
	logic ov_r;
	logic pump_r;
	logic supply_fault_flag_r;
	logic gerr_r;
	logic [3:0] dsf_r;
	logic [11:0] hold_r;
	logic ov_trip;
	logic pump_can_clr;
	logic tsd_can_clr;
	logic uv_can_clr;
	logic ov_can_clr;
	logic pump_evt;

	assign ov_trip      = ov_sel ? sup_high_s : sup_high_s & 1'b1;
	assign tsd_can_clr  = stat_clr && !shutdown_s;
	assign uv_can_clr   = stat_clr && sup_on_s && !sup_low_s;
	assign ov_can_clr   = stat_clr && sup_rec_s && !sup_ov_now();
	assign pump_can_clr = stat_clr && pump_ok_s && (hold_r == 12'h000);
	assign pump_evt     = !pump_ok_s;

	function automatic logic sup_ov_now();
		sup_ov_now = ov_sel ? flt_r[5] : flt_r[4];
	endfunction

	always_ff @(posedge mclk) begin
		if (!rst_n)
			tw_r <= 1'b0;
		else if (warn_s)
			tw_r <= 1'b1;
		else if (stat_clr)
			tw_r <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			tsd_r <= 1'b0;
		else if (shutdown_s)
			tsd_r <= 1'b1;
		else if (tsd_can_clr)
			tsd_r <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			uv_r <= 1'b0;
		else if (sup_low_s)
			uv_r <= 1'b1;
		else if (uv_can_clr)
			uv_r <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			ov_r <= 1'b0;
		else if (sup_ov_now())
			ov_r <= 1'b1;
		else if (ov_can_clr)
			ov_r <= 1'b0;
	end

	// Pump flag waits this long after supply or thermal recovery
	always_ff @(posedge mclk) begin
		if (!rst_n)
			hold_r <= 12'(`PUMP_HOLD_CYC);
		else if (tsd_r || uv_r || ov_r)
			hold_r <= 12'(`PUMP_HOLD_CYC);
		else if (hold_r != 12'h000)
			hold_r <= hold_r - 12'h001;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			pump_r <= 1'b0;
		else if (pump_evt || shutdown_s || sup_low_s || sup_ov_now())
			pump_r <= 1'b1;
		else if (pump_can_clr)
			pump_r <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			supply_fault_flag_r <= 1'b0;
		else if (pump_evt || shutdown_s || sup_low_s || sup_ov_now())
			supply_fault_flag_r <= 1'b1;
		else if (stat_clr && (!tsd_r || tsd_can_clr) && (!uv_r || uv_can_clr)
				&& (!ov_r || ov_can_clr) && (!pump_r || pump_can_clr))
			supply_fault_flag_r <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			gerr_r <= 1'b0;
		else if (pump_evt)
			gerr_r <= 1'b1;
		else if (pump_can_clr)
			gerr_r <= 1'b0;
	end

	// ************************************************************
	// Half-bridge sequencing
	// ************************************************************
	bridge_state_type st_r [4];
	logic [9:0]       gcnt_r [4];
	logic [9:0]       bcnt_r [4];
	logic [1:0]       drive_r [4];
	logic [3:0]       want;
	logic [3:0]       enabled;
	logic [9:0]       glen [4];
	logic [9:0]       blen [4];
	logic             drivers_ok;

	assign drivers_ok = !(tsd_r || uv_r || ov_r || pump_r) && !passive;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			logic [1:0] pair;
			pair = pair_map_r[2*b +: 2];
			enabled[b] = drivers_ok && !dsf_r[b];
			want[b] = enabled[b] && (mode_v[2*b +: 2] == 2'b01 || mode_v[2*b +: 2] == 2'b10);
			if (fw_role[b]) begin
				glen[b] = guard_cycles(pair_field(fw_a_r, fw_b_r, pair, 1'b0));
				blen[b] = blank_cycles(pair_field(fw_a_r, fw_b_r, pair, 1'b1));
			end else begin
				glen[b] = guard_cycles(pair_field(act_a_r, act_b_r, pair, 1'b0));
				blen[b] = blank_cycles(pair_field(act_a_r, act_b_r, pair, 1'b1));
			end
		end
	end

	always_ff @(posedge mclk) begin
		for (int b = 0; b < 4; b++) begin
			if (!rst_n) begin
				st_r[b]    <= ST_OFF;
				gcnt_r[b]  <= 10'h000;
				bcnt_r[b]  <= 10'h000;
				drive_r[b] <= 2'b00;
			end else begin
				if (bcnt_r[b] != 10'h000)
					bcnt_r[b] <= bcnt_r[b] - 10'h001;
				case (st_r[b])
					ST_OFF: begin
						if (want[b]) begin
							st_r[b]    <= ST_ON;
							drive_r[b] <= mode_v[2*b +: 2];
							bcnt_r[b]  <= blen[b];
						end
					end
					ST_ON: begin
						if (!enabled[b]) begin
							st_r[b]    <= ST_DISCHARGE;
							drive_r[b] <= 2'b00;
							gcnt_r[b]  <= glen[b];
						end else if (!want[b]) begin
							st_r[b]    <= ST_OFF;
							drive_r[b] <= 2'b00;
						end else if (mode_v[2*b +: 2] != drive_r[b]) begin
							st_r[b]    <= ST_GUARD;
							drive_r[b] <= 2'b00;
							gcnt_r[b]  <= glen[b];
						end
					end
					ST_GUARD: begin
						if (!want[b]) begin
							st_r[b] <= ST_OFF;
						end else if (gcnt_r[b] <= 10'h001) begin
							st_r[b]    <= ST_ON;
							drive_r[b] <= mode_v[2*b +: 2];
							bcnt_r[b]  <= blen[b];
						end else begin
							gcnt_r[b] <= gcnt_r[b] - 10'h001;
						end
					end
					ST_DISCHARGE: begin
						if (gcnt_r[b] <= 10'h001)
							st_r[b] <= ST_OFF;
						else
							gcnt_r[b] <= gcnt_r[b] - 10'h001;
					end
					default: begin
						st_r[b]    <= ST_OFF;
						drive_r[b] <= 2'b00;
					end
				endcase
			end
		end
	end

	// Drain faults latch the bridge off until cleared by writing ones
	always_ff @(posedge mclk) begin
		for (int b = 0; b < 4; b++) begin
			if (!rst_n)
				dsf_r[b] <= 1'b0;
			else if (st_r[b] == ST_ON && bcnt_r[b] == 10'h000 && drain_s[b])
				dsf_r[b] <= 1'b1;
			else if (drain_clr && wdata[b])
				dsf_r[b] <= 1'b0;
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	logic [31:0] rdata_r;
	logic [3:0]  lvl;

	always_comb begin
		for (int b = 0; b < 4; b++)
			lvl[b] = (mode_v[2*b +: 2] == 2'b00 || mode_v[2*b +: 2] == 2'b11) ? level_s[b] : 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			rdata_r <= 32'h0000_0000;
		else if (rd) begin
			case (addr)
				`OFS_PAIR_MAP:     rdata_r <= {24'h000000, pair_map_r};
				`OFS_ACT_A:        rdata_r <= {20'h00000, act_a_r};
				`OFS_ACT_B:        rdata_r <= {20'h00000, act_b_r};
				`OFS_FW_A:         rdata_r <= {20'h00000, fw_a_r};
				`OFS_FW_B:         rdata_r <= {20'h00000, fw_b_r};
				`OFS_BRIDGE_CTRL:  rdata_r <= {16'h0000, bctrl_r};
				`OFS_DIAG_CURRENT: rdata_r <= {28'h0000000, diag_r};
				`OFS_OUT_LEVEL:    rdata_r <= {28'h0000000, lvl};
				`OFS_GEN_STATUS:   rdata_r <= {25'h0000000, gerr_r, ov_r, uv_r, supply_fault_flag_r, pump_r, tsd_r, tw_r};
				`OFS_DRAIN_STATUS: rdata_r <= {28'h0000000, dsf_r};
				default:           rdata_r <= 32'h0000_0000;
			endcase
		end else
			rdata_r <= 32'h0000_0000;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign warn_s     = flt_r[0];
	assign shutdown_s = flt_r[1];
	assign sup_low_s  = flt_r[2];
	assign sup_on_s   = flt_r[3];
	assign sup_high_s = sup_ov_now();
	assign sup_rec_s  = flt_r[6];
	assign pump_ok_s  = flt_r[7];
	assign drain_s    = flt_r[11:8];
	assign level_s    = flt_r[15:12];

	assign passive = bctrl_r[`BC_PASSIVE];
	assign ov_sel  = bctrl_r[`BC_OV_SEL];
	assign mode_v  = bctrl_r[`BC_MODE_LSB +: 8];
	assign fw_role = bctrl_r[`BC_FW_LSB +: 4];

	assign rdata                    = rdata_r;
	assign static_discharge_current = bctrl_r[`BC_DIS_LSB +: 2];
	assign diag_pullup_on           = !passive;
	assign diag_pulldown_on         = diag_r & {4{!passive}};
	assign pump_enable              = !tsd_r && !sup_low_s && !(ov_r && !sup_rec_s);
	assign global_error             = gerr_r;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			high_on[b]          = drive_r[b][1];
			low_on[b]           = drive_r[b][0];
			static_discharge[b] = (st_r[b] == ST_DISCHARGE);
			blank_active[b]     = (bcnt_r[b] != 10'h000);
		end
	end

endmodule // gate_fault_supervisor

// ---- gfs_consts.svh ----
`ifndef GFS_CONSTS_SVH
`define GFS_CONSTS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_PAIR_MAP      8'h00
`define OFS_ACT_A         8'h04
`define OFS_ACT_B         8'h08
`define OFS_FW_A          8'h0C
`define OFS_FW_B          8'h10
`define OFS_BRIDGE_CTRL   8'h14
`define OFS_DIAG_CURRENT  8'h18
`define OFS_OUT_LEVEL     8'h1C
`define OFS_GEN_STATUS    8'h20
`define OFS_DRAIN_STATUS  8'h24

// ************************************************************
// Reset values
// ************************************************************
`define RST_PAIR_MAP      8'h00
`define RST_TIMING        12'h924
`define RST_BRIDGE_CTRL   16'h0000
`define RST_DIAG_CURRENT  4'h0

// ************************************************************
// Bridge control field positions
// ************************************************************
`define BC_MODE_LSB       0
`define BC_PASSIVE        8
`define BC_OV_SEL         9
`define BC_DIS_LSB        10
`define BC_FW_LSB         12

// ************************************************************
// General status field positions
// ************************************************************
`define GS_TW             0
`define GS_TSD            1
`define GS_PUMP           2
`define GS_SUPPLY_FAULT_FLAG           3
`define GS_SUPPLY_LOW_FLAG           4
`define GS_SUPPLY_HIGH_FLAG           5
`define GS_GERR           6

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS     20
`define NS_TO_CYC(t)      (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_T0_NS       625
`define BLANK_T1_NS       1000
`define BLANK_T2_NS       1250
`define BLANK_T3_NS       1500
`define BLANK_T4_NS       2000
`define BLANK_T5_NS       3000
`define BLANK_T6_NS       4000
`define BLANK_T7_NS       16000
`define GUARD_T0_NS       375
`define GUARD_T1_NS       625
`define GUARD_T2_NS       1000
`define GUARD_T3_NS       1500
`define GUARD_T4_NS       2000
`define GUARD_T5_NS       3000
`define GUARD_T6_NS       4000
`define GUARD_T7_NS       16000
`define PUMP_HOLD_NS      64000
`define PUMP_HOLD_CYC     `NS_TO_CYC(`PUMP_HOLD_NS)

`endif

// ---- gfs_pkg.sv ----
package gfs_pkg;

	typedef logic [7:0]  reg_addr_type;
	typedef logic [31:0] reg_data_type;
	typedef logic [3:0]  bridge_vec_type;

	// Gray order along off -> guard -> on -> discharge
	typedef enum logic [1:0] {
		ST_OFF       = 2'b00,
		ST_GUARD     = 2'b01,
		ST_ON        = 2'b11,
		ST_DISCHARGE = 2'b10
	} bridge_state_type;

endpackage

// ---- gfs_bridge_model.sv ----
module gfs_bridge_model (
	input  wire logic                    mclk,
	input  wire gfs_pkg::bridge_vec_type high_on,
	input  wire gfs_pkg::bridge_vec_type low_on,
	input  wire gfs_pkg::bridge_vec_type diag_pulldown_on,
	input  wire logic                    diag_pullup_on,
	input  wire gfs_pkg::bridge_vec_type short_cmd,
	output gfs_pkg::bridge_vec_type      out_level_in,
	output gfs_pkg::bridge_vec_type      drain_over_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import gfs_pkg::*;
	// ***
	// External switches and output node
	// ***
	bridge_vec_type float_r = '0;
	// Undriven, unpulled node wanders each cycle
	always @(posedge mclk) float_r <= ~float_r;
	// Pull-down outweighs pull-up
	assign out_level_in = high_on | (~low_on & ~diag_pulldown_on & ({4{diag_pullup_on}} | float_r));
	// Shorted switch shows drain overvoltage only while on
	assign drain_over_in = short_cmd & (high_on | low_on);
endmodule // gfs_bridge_model

// ---- gfs_checker_asserts.sv ----
module gfs_checker (
	input wire logic                    mclk,
	input wire logic                    rst_n,
	input wire gfs_pkg::reg_addr_type   addr,
	input wire logic                    wr,
	input wire gfs_pkg::bridge_vec_type high_on,
	input wire gfs_pkg::bridge_vec_type low_on,
	input wire gfs_pkg::bridge_vec_type static_discharge,
	input wire gfs_pkg::bridge_vec_type blank_active,
	input wire gfs_pkg::bridge_vec_type diag_pulldown_on,
	input wire logic                    diag_pullup_on,
	input wire logic                    temp_shutdown_in,
	input wire logic                    supply_below_off_in,
	input wire logic                    pump_enable,
	input wire logic                    global_error
);
	timeunit 1ns;
	timeprecision 1ps;
	import gfs_pkg::*;
	// ***
	// Port relations
	// ***
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	bridge_vec_type drv;
	assign drv = high_on | low_on;

	a_no_cross: assert property ((high_on & low_on) == '0)
		else $error("both sides on");
	a_blank_turnon: assert property ((drv & ~$past(drv) & ~blank_active) == '0)
		else $error("turn-on without blanking");
	a_blank_min: assert property ($rose(blank_active[0]) |-> blank_active[0] [*8])
		else $error("blanking too short");
	a_disch_nodrive: assert property ((static_discharge & drv) == '0)
		else $error("discharge while driven");
	a_disch_min: assert property ($rose(static_discharge[0]) |-> static_discharge[0] [*8])
		else $error("discharge too short");
	a_pulldown_passive: assert property (!diag_pullup_on |-> diag_pulldown_on == '0)
		else $error("pull-down while passive");
	a_shutdown_off: assert property (temp_shutdown_in [*8] |-> ##2 (drv == '0 && !pump_enable))
		else $error("drive or pump on in shutdown");
	a_lowsupply_off: assert property (supply_below_off_in [*8] |-> ##2 drv == '0)
		else $error("drive on at low supply");
	a_gerr_clear: assert property ($fell(global_error) |-> $past(wr) && $past(addr) == 8'h20)
		else $error("global error fell without clear");

	cover property ($rose(blank_active[0]));
	cover property ($rose(static_discharge[0]));
	cover property ($fell(global_error));
endmodule // gfs_checker

bind gate_fault_supervisor gfs_checker chk_u (.mclk, .rst_n, .addr, .wr, .high_on, .low_on,
	.static_discharge, .blank_active, .diag_pulldown_on, .diag_pullup_on, .temp_shutdown_in,
	.supply_below_off_in, .pump_enable, .global_error);

// ---- gate_driver_fault_supervisor_tb.sv ----
module gate_driver_fault_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gfs_pkg::*;
	logic           mclk, rst_n, wr, rd, temp_warn_in, temp_shutdown_in, supply_below_off_in;
	logic           supply_above_on_in, supply_over1_in, supply_over2_in, supply_below_rec_in;
	logic           pump_ok_in, diag_pullup_on, pump_enable, global_error;
	logic [1:0]     static_discharge_current;
	reg_addr_type   addr;
	reg_data_type   wdata, rdata, v;
	bridge_vec_type drain_over_in, out_level_in, high_on, low_on, static_discharge;
	bridge_vec_type blank_active, diag_pulldown_on, short_cmd;
	int             fail_count, comparisons, i, n;
	int             blank_cyc[8] = '{32, 50, 63, 75, 100, 150, 200, 800};

	gate_fault_supervisor dut (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .temp_warn_in,
		.temp_shutdown_in, .supply_below_off_in, .supply_above_on_in, .supply_over1_in,
		.supply_over2_in, .supply_below_rec_in, .pump_ok_in, .drain_over_in, .out_level_in,
		.high_on, .low_on, .static_discharge, .static_discharge_current, .blank_active,
		.diag_pulldown_on, .diag_pullup_on, .pump_enable, .global_error);
	gfs_bridge_model mosfets (.mclk, .high_on, .low_on, .diag_pulldown_on, .diag_pullup_on,
		.short_cmd, .out_level_in, .drain_over_in);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// ***
	// Bus and check tasks
	// ***
	task automatic chk(input string nm, input reg_data_type g, input reg_data_type e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge mclk);
	endtask
	task automatic wr_reg(input reg_addr_type a, input reg_data_type d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input string nm, input reg_addr_type a, input reg_data_type m, input reg_data_type e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
		chk(nm, v & m, e);
	endtask
	// Length of a run of blanking, discharge or idle drive on one bridge
	task automatic span(input int sel, input int b);
		n = 0;
		for (int k = 0; k < 3000; k++) begin
			#1;
			if (sel == 0 ? blank_active[b] : sel == 1 ? static_discharge[b] : !(high_on[b] | low_on[b]))
				n++;
			else if (n > 0)
				break;
			@(posedge mclk);
		end
	endtask
	task automatic recover();
		cyc(8);
		wr_reg(8'h20, 32'h0);
		cyc(3300);
		wr_reg(8'h20, 32'h0);
		span(0, 0);
		chk("reactivation blank", n, 32'd32);
		rchk("status clear", 8'h20, 32'hFF, 32'h0);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge mclk);
		fail_count++;
		test_done();
	end
	// ***
	// Test sequence
	// ***
	initial begin
		{rst_n, wr, rd, addr, wdata, short_cmd} = '0;
		{temp_warn_in, temp_shutdown_in, supply_below_off_in, supply_over1_in, supply_over2_in} = '0;
		{supply_above_on_in, supply_below_rec_in, pump_ok_in} = 3'b111;
		fail_count = 0;
		comparisons = 0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		for (i = 0; i < 7; i++)
			rchk("reset", (i == 6) ? 8'h30 : 8'(i * 4), '1, (i > 0 && i < 5) ? 32'h924 : 32'h0);
		cyc(3300);
		wr_reg(8'h20, 32'h0);
		rchk("power-up status", 8'h20, 32'hFF, 32'h0);
		for (i = 0; i < 8; i++) begin
			wr_reg(8'h04, 32'h904 | (i << 3));
			wr_reg(8'h14, 32'h1);
			span(0, 0);
			chk("blank", n, blank_cyc[i]);
			chk("low on", low_on, 4'h1);
			wr_reg(8'h14, 32'h0);
			cyc(120);
		end
		wr_reg(8'h04, 32'h304);
		wr_reg(8'h08, 32'h714);
		for (i = 0; i < 4; i++) begin
			wr_reg(8'h00, i << 2);
			wr_reg(8'h14, 32'h4);
			span(0, 1);
			chk("mapped blank", n, blank_cyc[i]);
			wr_reg(8'h14, 32'h0);
			cyc(120);
		end
		wr_reg(8'h0C, 32'h93C);
		wr_reg(8'h14, 32'h1001);
		span(0, 0);
		chk("freewheel blank", n, 32'd800);
		wr_reg(8'h14, 32'h0);
		cyc(120);
		wr_reg(8'h14, 32'h1);
		span(0, 0);
		chk("active blank", n, 32'd32);
		wr_reg(8'h14, 32'h2);
		span(2, 0);
		chk("guard gap", n, 32'd100);
		chk("blank at switch", {high_on[0], blank_active[0]}, 2'b11);
		cyc(8);
		rchk("level on", 8'h1C, 32'hF, 32'hE);
		wr_reg(8'h14, 32'hC03);
		cyc(8);
		chk("discharge current", static_discharge_current, 2'b11);
		rchk("level off", 8'h1C, 32'hF, 32'hF);
		wr_reg(8'h18, 32'h1);
		cyc(8);
		chk("pulls", {diag_pulldown_on, diag_pullup_on}, 5'h03);
		rchk("level pulled", 8'h1C, 32'hF, 32'hE);
		wr_reg(8'h14, 32'h103);
		cyc(2);
		chk("passive pulls", {diag_pulldown_on, diag_pullup_on}, 5'h00);
		wr_reg(8'h18, 32'h0);
		wr_reg(8'h14, 32'h1);
		short_cmd <= 4'h1;
		cyc(10);
		rchk("drain in blank", 8'h24, 32'hF, 32'h0);
		cyc(40);
		rchk("drain fault", 8'h24, 32'hF, 32'h1);
		chk("drain off", low_on, 4'h0);
		short_cmd <= 4'h0;
		wr_reg(8'h24, 32'h1);
		rchk("drain clear", 8'h24, 32'hF, 32'h0);
		cyc(120);
		pump_ok_in <= 1'b0;
		span(1, 0);
		chk("discharge span", n, 32'd100);
		chk("pump fault", {low_on[0], global_error}, 2'b01);
		rchk("pump flags", 8'h20, 32'hFF, 32'h4C);
		pump_ok_in <= 1'b1;
		cyc(8);
		wr_reg(8'h20, 32'h0);
		rchk("pump clear", 8'h20, 32'hFF, 32'h0);
		cyc(120);
		temp_warn_in <= 1'b1;
		cyc(8);
		wr_reg(8'h20, 32'h0);
		rchk("warn kept", 8'h20, 32'hFF, 32'h1);
		chk("warn drive", low_on, 4'h1);
		temp_warn_in <= 1'b0;
		cyc(8);
		rchk("warn latched", 8'h20, 32'hFF, 32'h1);
		wr_reg(8'h20, 32'h0);
		rchk("warn clear", 8'h20, 32'hFF, 32'h0);
		temp_shutdown_in <= 1'b1;
		cyc(12);
		chk("shutdown out", {low_on[0], pump_enable}, 2'b00);
		rchk("shutdown flags", 8'h20, 32'h3F, 32'h0E);
		wr_reg(8'h20, 32'h0);
		rchk("shutdown kept", 8'h20, 32'h3F, 32'h0E);
		temp_shutdown_in <= 1'b0;
		cyc(8);
		wr_reg(8'h20, 32'h0);
		rchk("pump hold", 8'h20, 32'h3F, 32'h0C);
		chk("shutdown drive", low_on, 4'h0);
		recover();
		{supply_below_off_in, supply_above_on_in} <= 2'b10;
		cyc(12);
		chk("low supply drive", low_on, 4'h0);
		rchk("low supply flags", 8'h20, 32'h3F, 32'h1C);
		supply_below_off_in <= 1'b0;
		cyc(8);
		wr_reg(8'h20, 32'h0);
		rchk("low supply kept", 8'h20, 32'h3F, 32'h1C);
		supply_above_on_in <= 1'b1;
		recover();
		{supply_over1_in, supply_below_rec_in} <= 2'b10;
		cyc(12);
		chk("high supply out", {low_on[0], pump_enable}, 2'b00);
		rchk("high supply flags", 8'h20, 32'h3F, 32'h2C);
		supply_over1_in <= 1'b0;
		cyc(8);
		wr_reg(8'h20, 32'h0);
		rchk("high supply kept", 8'h20, 32'h3F, 32'h2C);
		supply_below_rec_in <= 1'b1;
		cyc(8);
		chk("pump restart", {low_on[0], pump_enable}, 2'b01);
		recover();
		wr_reg(8'h14, 32'h201);
		{supply_over1_in, supply_below_rec_in} <= 2'b10;
		cyc(12);
		chk("second level", low_on, 4'h1);
		supply_over2_in <= 1'b1;
		cyc(12);
		chk("second level trip", low_on, 4'h0);
		{supply_over1_in, supply_over2_in, supply_below_rec_in} <= 3'b001;
		recover();
		rst_n <= 1'b0;
		cyc(3);
		#1;
		chk("reset drive", {high_on, low_on, blank_active, static_discharge}, 16'h0);
		chk("reset pump pulls", {pump_enable, diag_pullup_on, global_error}, 3'b110);
		@(posedge mclk);
		rst_n <= 1'b1;
		rchk("reset control", 8'h14, 32'hFFFF, 32'h0);
		test_done();
	end
endmodule // gate_driver_fault_supervisor_tb
